// *** hw/wcf_axil_slave.v ***
`default_nettype none
`include "wcf_defs.vh"
// AXI4-Lite slave: one write and one read at a time, read answer one cycle after take, write answer two cycles after the later of address and data
module wcf_axil_slave (
	input wire aclk, // Clock
	input wire aresetn, // Synchronous reset, active low
	input wire [7:0] s_axi_awaddr, // Write address
	input wire s_axi_awvalid, // Write address valid
	output reg s_axi_awready, // Write address ready
	input wire [31:0] s_axi_wdata, // Write data
	input wire [3:0] s_axi_wstrb, // Write strobes
	input wire s_axi_wvalid, // Write data valid
	output reg s_axi_wready, // Write data ready
	output reg [1:0] s_axi_bresp, // Write response
	output reg s_axi_bvalid, // Write response valid
	input wire s_axi_bready, // Write response ready
	input wire [7:0] s_axi_araddr, // Read address
	input wire s_axi_arvalid, // Read address valid
	output reg s_axi_arready, // Read address ready
	output reg [31:0] s_axi_rdata, // Read data
	output reg [1:0] s_axi_rresp, // Read response
	output reg s_axi_rvalid, // Read response valid
	input wire s_axi_rready, // Read response ready
	output reg wr_pulse, // One-cycle register write
	output reg [7:0] wr_addr, // Write address, word aligned
	output reg [31:0] wr_data, // Write data
	output reg [3:0] wr_strb, // Write strobes
	input wire wr_ok, // Address is mapped for writing
	output wire [7:0] rd_addr, // Read address to decode
	input wire [31:0] rd_data, // Read data for rd_addr
	input wire rd_ok // Address is mapped for reading
);
	reg aw_have_reg;
	reg w_have_reg;
	reg [7:0] ar_addr_reg;
	assign rd_addr = s_axi_araddr;
	always @(posedge aclk) begin
		wr_pulse <= 1'b0;
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= 2'h0;
			s_axi_rdata <= 32'h0000_0000;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
			ar_addr_reg <= 8'h00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				wr_addr <= {s_axi_awaddr[7:2], 2'b00};
				aw_have_reg <= 1'b1;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
				w_have_reg <= 1'b1;
				s_axi_wready <= 1'b0;
			end
			if (aw_have_reg && w_have_reg && !s_axi_bvalid) begin
				wr_pulse <= 1'b1;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? 2'h0 : 2'h2;
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_ok ? rd_data : 32'h0000_0000;
				s_axi_rresp <= rd_ok ? 2'h0 : 2'h2;
				ar_addr_reg <= s_axi_araddr;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// *** hw/wcf_dec_digits.v ***
`default_nettype none
// Splits an 8-bit value into decimal digits, leading zeros marked absent
module wcf_dec_digits (
	input wire [7:0] value, // Point value
	output wire [7:0] ch_hund, // ASCII hundreds digit
	output wire [7:0] ch_tens, // ASCII tens digit
	output wire [7:0] ch_ones, // ASCII ones digit
	output wire [1:0] ndig // Number of digits minus one
);
	wire [7:0] h;
	wire [7:0] rem;
	wire [7:0] t;
	assign h = value / 8'd100;
	assign rem = value - h * 8'd100;
	assign t = rem / 8'd10;
	assign ch_hund = h + 8'h30;
	assign ch_tens = t + 8'h30;
	assign ch_ones = (rem - t * 8'd10) + 8'h30;
	assign ndig = (h != 8'h00) ? 2'h2 : ((t != 8'h00) ? 2'h1 : 2'h0);
endmodule
`default_nettype wire

// *** hw/wcf_defs.vh ***
`ifndef WCF_DEFS_VH
`define WCF_DEFS_VH
// Register byte offsets
`define WCF_CTRL_OFS 8'h00
`define WCF_CFG_OFS 8'h04
`define WCF_STAT_OFS 8'h08
`define WCF_PREW_OFS 8'h0c
`define WCF_SMPW_OFS 8'h10
// Control fields
`define WCF_CTRL_START_BIT 0
`define WCF_CTRL_QSEL_LSB 1
// Configuration fields
`define WCF_CFG_ENC_LSB 0
`define WCF_CFG_WIDE_BIT 2
`define WCF_CFG_TERM_BIT 3
`define WCF_CFG_XON_BIT 4
`define WCF_CFG_NPTS_LSB 16
`define WCF_CFG_RST 32'h0000_0000
// Preamble length field
`define WCF_PREW_LEN_LSB 16
// Status fields
`define WCF_STAT_BUSY_BIT 0
`define WCF_STAT_REFUSED_BIT 1
`define WCF_STAT_DONE_BIT 2
// Query kinds
`define WCF_Q_CURVE 2'h0
`define WCF_Q_PRE 2'h1
`define WCF_Q_FULL 2'h2
// Encodings
`define WCF_ENC_RAW 2'h0
`define WCF_ENC_HEX 2'h1
`define WCF_ENC_DEC 2'h2
// Characters
`define WCF_CH_SP 8'h20
`define WCF_CH_PCT 8'h25
`define WCF_CH_HASH 8'h23
`define WCF_CH_H 8'h48
`define WCF_CH_COMMA 8'h2c
`define WCF_CH_SEMI 8'h3b
`define WCF_CH_CR 8'h0d
`define WCF_CH_LF 8'h0a
`endif

// *** hw/wcf_framer.v ***
`default_nettype none
`include "wcf_defs.vh"
//////////////////////////////////////////////////////////////////////////////
// Operation
// R1 - Curve, preamble, or preamble then curve
// R2 - Semicolon between preamble and curve
// R3 - 8-bit samples sent raw, hex or decimal
// R4 - Record 1024/4096; point count field sets length
// R5 - Raw: CURVE space percent count data checksum term
// R6 - Count is data bytes plus one, high first
// R7 - Point is one byte, two when averaged
// R8 - 256 to 4096 points, 8 or 16 bits; 16-bit fetch wraps after 2048 points
// R9 - Checksum negates modulo-256 sum of count, data
// R10 - End marker on checksum, or CR LF with LF
// R11 - Hex header uses hash and H
// R12 - Hex point two or four characters, MSN first
// R13 - No separators between hex points
// R14 - Hex count four characters, raw value
// R15 - Hex checksum two characters, high first
// R16 - Decimal: CURVE space, comma between points
// R17 - Decimal digits without leading zeros
// R18 - Two-byte point sends MSB first
// R19 - Refuse raw transfer while XON/XOFF enabled
// R20 - Header characters excluded from checksum
// R21 - Decimal has no count nor checksum
// R22 - Controller verifies checksum against received bytes
module wcf_framer #(
	parameter REC_MAX = 4096, // Stored record entries
	parameter PRE_MAX = 256 // Preamble buffer bytes
) (
	input wire aclk, // Clock, 50 MHz
	input wire aresetn, // Synchronous reset, active low
	input wire [7:0] s_axi_awaddr, // Write address
	input wire s_axi_awvalid, // Write address valid
	output wire s_axi_awready, // Write address ready
	input wire [31:0] s_axi_wdata, // Write data
	input wire [3:0] s_axi_wstrb, // Write strobes
	input wire s_axi_wvalid, // Write data valid
	output wire s_axi_wready, // Write data ready
	output wire [1:0] s_axi_bresp, // Write response
	output wire s_axi_bvalid, // Write response valid
	input wire s_axi_bready, // Write response ready
	input wire [7:0] s_axi_araddr, // Read address
	input wire s_axi_arvalid, // Read address valid
	output wire s_axi_arready, // Read address ready
	output wire [31:0] s_axi_rdata, // Read data
	output wire [1:0] s_axi_rresp, // Read response
	output wire s_axi_rvalid, // Read response valid
	input wire s_axi_rready, // Read response ready
	output reg [7:0] tx_data, // Outgoing byte
	output reg tx_valid, // Byte valid
	input wire tx_ready, // Link takes byte
	output reg tx_end // Bus end marker with this byte
);
	localparam S_IDLE = 4'h0;
	localparam S_PRE = 4'h1;
	localparam S_SEMI = 4'h2;
	localparam S_HDR = 4'h3;
	localparam S_CNT = 4'h4;
	localparam S_FETCH = 4'h5;
	localparam S_DATA = 4'h6;
	localparam S_SUM = 4'h7;
	localparam S_CR = 4'h8;
	localparam S_LF = 4'h9;
	localparam S_EMIT = 4'ha;

	reg [7:0] rec_mem [0:REC_MAX-1];
	reg [7:0] pre_mem [0:PRE_MAX-1];
	reg [31:0] cfg_reg;
	reg [15:0] pre_len_reg;
	reg [12:0] smp_wptr_reg;
	reg [7:0] pre_wptr_reg;
	reg busy_reg;
	reg refused_reg;
	reg done_reg;
	reg [1:0] q_reg;
	reg [3:0] st_reg;
	reg [1:0] enc_reg;
	reg wide_reg;
	reg term_lf_reg;
	reg [12:0] npts_reg;
	reg [15:0] idx_reg;
	reg [2:0] sub_reg;
	reg [15:0] cnt_reg;
	reg [7:0] sum_reg;
	reg [7:0] val_reg;
	reg [7:0] val_lo_reg;

	wire wr_pulse;
	wire [7:0] wr_addr;
	wire [31:0] wr_data;
	wire [3:0] wr_strb;
	wire [7:0] rd_addr;
	reg [31:0] rd_data;
	wire rd_ok;
	wire wr_ok;
	wire [7:0] d_h;
	wire [7:0] d_t;
	wire [7:0] d_o;
	wire [1:0] d_n;

	function [7:0] hex_ch;
		input [3:0] n;
		begin
			hex_ch = (n < 4'ha) ? {4'h3, n} : (8'h37 + {4'h0, n});
		end
	endfunction

	function [7:0] hdr_ch;
		input [2:0] i;
		begin
			case (i)
				3'h0: hdr_ch = 8'h43;
				3'h1: hdr_ch = 8'h55;
				3'h2: hdr_ch = 8'h52;
				3'h3: hdr_ch = 8'h56;
				3'h4: hdr_ch = 8'h45;
				default: hdr_ch = `WCF_CH_SP;
			endcase
		end
	endfunction

	wcf_axil_slave u_bus (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .wr_pulse(wr_pulse), .wr_addr(wr_addr),
		.wr_data(wr_data), .wr_strb(wr_strb), .wr_ok(wr_ok),
		.rd_addr(rd_addr), .rd_data(rd_data), .rd_ok(rd_ok)
	);

	wcf_dec_digits u_dec (
		.value(val_reg), .ch_hund(d_h), .ch_tens(d_t), .ch_ones(d_o), .ndig(d_n)
	);

	assign wr_ok = (wr_addr <= `WCF_SMPW_OFS);
	assign rd_ok = ({rd_addr[7:2], 2'b00} <= `WCF_SMPW_OFS);

	always @* begin
		case ({rd_addr[7:2], 2'b00})
			`WCF_CTRL_OFS: rd_data = {29'h0, q_reg, busy_reg};
			`WCF_CFG_OFS: rd_data = cfg_reg;
			`WCF_STAT_OFS: rd_data = {29'h0, done_reg, refused_reg, busy_reg};
			`WCF_PREW_OFS: rd_data = {pre_len_reg, 8'h00, pre_wptr_reg};
			`WCF_SMPW_OFS: rd_data = {19'h0, smp_wptr_reg};
			default: rd_data = 32'h0000_0000;
		endcase
	end

	//////////////////////////////////////////////////////////////////////////////
	// Stored record and preamble loading; the stores fill while idle only
	always @(posedge aclk) begin
		if (wr_pulse && !busy_reg && wr_addr == `WCF_SMPW_OFS && wr_strb[0])
			rec_mem[smp_wptr_reg[11:0]] <= wr_data[7:0]; // [R3] [R4]
		if (wr_pulse && !busy_reg && wr_addr == `WCF_PREW_OFS && wr_strb[0])
			pre_mem[pre_wptr_reg] <= wr_data[7:0];
	end

	//////////////////////////////////////////////////////////////////////////////
	// Registers and framing engine
	wire start_req = wr_pulse && wr_addr == `WCF_CTRL_OFS && wr_strb[0] &&
		wr_data[`WCF_CTRL_START_BIT] && !busy_reg;
	wire [1:0] start_q = wr_data[`WCF_CTRL_QSEL_LSB+1:`WCF_CTRL_QSEL_LSB];
	wire curve_part = (start_q != `WCF_Q_PRE);
	wire [15:0] data_bytes = cfg_reg[`WCF_CFG_WIDE_BIT] ?
		{2'b00, cfg_reg[28:16], 1'b0} : {3'b000, cfg_reg[28:16]};
	wire tx_free = !tx_valid || tx_ready;
	wire [7:0] sum_neg = 8'h00 - sum_reg;
	wire last_pt = (idx_reg == {3'b000, npts_reg} - 16'h0001);

	always @(posedge aclk) begin
		if (!aresetn) begin
			cfg_reg <= `WCF_CFG_RST;
			pre_len_reg <= 16'h0000;
			smp_wptr_reg <= 13'h0000;
			pre_wptr_reg <= 8'h00;
			busy_reg <= 1'b0;
			refused_reg <= 1'b0;
			done_reg <= 1'b0;
			q_reg <= 2'h0;
			st_reg <= S_IDLE;
			enc_reg <= 2'h0;
			wide_reg <= 1'b0;
			term_lf_reg <= 1'b0;
			npts_reg <= 13'h0000;
			idx_reg <= 16'h0000;
			sub_reg <= 3'h0;
			cnt_reg <= 16'h0000;
			sum_reg <= 8'h00;
			val_reg <= 8'h00;
			val_lo_reg <= 8'h00;
			tx_data <= 8'h00;
			tx_valid <= 1'b0;
			tx_end <= 1'b0;
		end else begin
			if (tx_valid && tx_ready) begin
				tx_valid <= 1'b0;
				tx_end <= 1'b0;
			end
			if (wr_pulse && !busy_reg) begin
				if (wr_addr == `WCF_CFG_OFS)
					cfg_reg <= wr_data;
				if (wr_addr == `WCF_PREW_OFS) begin
					pre_len_reg <= wr_data[31:16];
					pre_wptr_reg <= (wr_strb[0]) ? pre_wptr_reg + 8'h01 : 8'h00;
				end
				if (wr_addr == `WCF_SMPW_OFS)
					smp_wptr_reg <= (wr_strb[0]) ? smp_wptr_reg + 13'h0001 : 13'h0000;
			end
			// Refused and done flags clear by writing ones while idle; a new start wins over the clear
			if (wr_pulse && wr_addr == `WCF_STAT_OFS && !busy_reg) begin
				if (wr_data[`WCF_STAT_REFUSED_BIT])
					refused_reg <= 1'b0;
				if (wr_data[`WCF_STAT_DONE_BIT])
					done_reg <= 1'b0;
			end
			case (st_reg)
				S_IDLE: begin
					if (start_req) begin
						done_reg <= 1'b0;
						if (curve_part && cfg_reg[`WCF_CFG_XON_BIT] &&
							cfg_reg[1:0] == `WCF_ENC_RAW) begin
							refused_reg <= 1'b1; // [R19]
						end else begin
							busy_reg <= 1'b1;
							q_reg <= start_q;
							enc_reg <= cfg_reg[1:0]; // [R3]
							wide_reg <= cfg_reg[`WCF_CFG_WIDE_BIT]; // [R7] [R8]
							term_lf_reg <= cfg_reg[`WCF_CFG_TERM_BIT];
							npts_reg <= cfg_reg[28:16]; // [R4] [R8]
							cnt_reg <= data_bytes + 16'h0001; // [R6]
							sum_reg <= 8'h00; // [R20]
							idx_reg <= 16'h0000;
							sub_reg <= 3'h0;
							st_reg <= (start_q == `WCF_Q_CURVE) ? S_HDR : S_PRE; // [R1]
						end
					end
				end
				S_PRE: if (tx_free) begin
					if (idx_reg >= pre_len_reg) begin
						idx_reg <= 16'h0000;
						st_reg <= (q_reg == `WCF_Q_FULL) ? S_SEMI : S_CR; // [R1]
					end else begin
						tx_data <= pre_mem[idx_reg[7:0]];
						tx_valid <= 1'b1;
						idx_reg <= idx_reg + 16'h0001;
					end
				end
				S_SEMI: if (tx_free) begin
					tx_data <= `WCF_CH_SEMI; // [R2]
					tx_valid <= 1'b1;
					st_reg <= S_HDR;
				end
				S_HDR: if (tx_free) begin
					tx_valid <= 1'b1;
					sub_reg <= sub_reg + 3'h1;
					if (sub_reg < 3'h6) begin
						tx_data <= hdr_ch(sub_reg); // [R5] [R16]
						if (sub_reg == 3'h5 && enc_reg == `WCF_ENC_DEC) begin
							sub_reg <= 3'h0;
							st_reg <= S_FETCH;
						end
					end else if (enc_reg == `WCF_ENC_RAW) begin
						tx_data <= `WCF_CH_PCT; // [R5]
						sub_reg <= 3'h0;
						st_reg <= S_CNT;
					end else begin
						tx_data <= (sub_reg == 3'h6) ? `WCF_CH_HASH : `WCF_CH_H; // [R11]
						if (sub_reg == 3'h7) begin
							sub_reg <= 3'h0;
							st_reg <= S_CNT;
						end
					end
				end
				S_CNT: if (tx_free) begin
					tx_valid <= 1'b1;
					sub_reg <= sub_reg + 3'h1;
					if (enc_reg == `WCF_ENC_RAW) begin
						tx_data <= sub_reg[0] ? cnt_reg[7:0] : cnt_reg[15:8]; // [R6]
						sum_reg <= sum_reg + (sub_reg[0] ? cnt_reg[7:0] : cnt_reg[15:8]); // [R9]
						if (sub_reg == 3'h1) begin
							sub_reg <= 3'h0;
							st_reg <= S_FETCH;
						end
					end else begin
						tx_data <= hex_ch(cnt_reg[15-4*sub_reg[1:0] -: 4]); // [R14]
						if (sub_reg[0])
							sum_reg <= sum_reg + (sub_reg[1] ? cnt_reg[7:0] : cnt_reg[15:8]);
						if (sub_reg == 3'h3) begin
							sub_reg <= 3'h0;
							st_reg <= S_FETCH;
						end
					end
				end
				S_FETCH: begin
					// Memory read takes a cycle; 16-bit points pack as MSB then LSB entries
					val_reg <= rec_mem[wide_reg ? {idx_reg[10:0], 1'b0} : idx_reg[11:0]];
					val_lo_reg <= rec_mem[{idx_reg[10:0], 1'b1}];
					sub_reg <= 3'h0;
					st_reg <= S_DATA;
				end
				S_DATA: if (tx_free) begin
					tx_valid <= 1'b1;
					sub_reg <= sub_reg + 3'h1;
					st_reg <= S_DATA;
					if (enc_reg == `WCF_ENC_RAW) begin
						tx_data <= sub_reg[0] ? val_lo_reg : val_reg; // [R18]
						sum_reg <= sum_reg + (sub_reg[0] ? val_lo_reg : val_reg); // [R9]
						if (sub_reg[0] || !wide_reg)
							st_reg <= last_pt ? S_SUM : S_FETCH;
					end else if (enc_reg == `WCF_ENC_HEX) begin
						tx_data <= hex_ch(sub_reg[1] ? (sub_reg[0] ? val_lo_reg[3:0] :
							val_lo_reg[7:4]) : (sub_reg[0] ? val_reg[3:0] : val_reg[7:4])); // [R12]
						if (sub_reg[0])
							sum_reg <= sum_reg + (sub_reg[1] ? val_lo_reg : val_reg);
						if (sub_reg == (wide_reg ? 3'h3 : 3'h1))
							st_reg <= last_pt ? S_SUM : S_FETCH; // [R13]
					end else begin
						// Decimal: digits from hundreds down, then comma unless last point; no count or sum
						if (sub_reg == 3'h0)
							tx_data <= (d_n == 2'h2) ? d_h : ((d_n == 2'h1) ? d_t : d_o); // [R17]
						else if (sub_reg == 3'h1)
							tx_data <= (d_n == 2'h2) ? d_t : d_o;
						else
							tx_data <= d_o;
						if (sub_reg == {1'b0, d_n}) begin
							st_reg <= last_pt ? S_CR : S_EMIT; // [R21]
						end
					end
					if (enc_reg != `WCF_ENC_DEC || sub_reg == {1'b0, d_n})
						idx_reg <= (st_reg == S_DATA && (enc_reg == `WCF_ENC_DEC || sub_reg[0] ||
							!wide_reg || enc_reg == `WCF_ENC_HEX) &&
							!(enc_reg == `WCF_ENC_HEX && sub_reg != (wide_reg ? 3'h3 : 3'h1)) &&
							!(enc_reg == `WCF_ENC_RAW && wide_reg && !sub_reg[0])) ?
							idx_reg + 16'h0001 : idx_reg;
				end
				S_EMIT: if (tx_free) begin
					tx_data <= `WCF_CH_COMMA; // [R16]
					tx_valid <= 1'b1;
					st_reg <= S_FETCH;
				end
				S_SUM: if (tx_free) begin
					tx_valid <= 1'b1;
					sub_reg <= sub_reg + 3'h1;
					if (enc_reg == `WCF_ENC_RAW) begin
						tx_data <= sum_neg; // [R9]
						tx_end <= !term_lf_reg; // [R10]
						st_reg <= term_lf_reg ? S_CR : S_IDLE;
					end else begin
						tx_data <= hex_ch(sub_reg[0] ? sum_neg[3:0] : sum_neg[7:4]); // [R15]
						if (sub_reg[0]) begin
							tx_end <= !term_lf_reg; // [R10]
							st_reg <= term_lf_reg ? S_CR : S_IDLE;
						end
					end
					if (!term_lf_reg && (enc_reg == `WCF_ENC_RAW || sub_reg[0])) begin
						busy_reg <= 1'b0;
						done_reg <= 1'b1;
					end
				end
				S_CR: if (tx_free) begin
					tx_data <= `WCF_CH_CR; // [R10]
					tx_valid <= 1'b1;
					st_reg <= S_LF;
				end
				S_LF: if (tx_free) begin
					tx_data <= `WCF_CH_LF;
					tx_valid <= 1'b1;
					tx_end <= 1'b1; // [R10]
					busy_reg <= 1'b0;
					done_reg <= 1'b1;
					st_reg <= S_IDLE;
				end
				default: st_reg <= S_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// *** testbench/waveform_curve_framer_tb_top.sv ***
`default_nettype none
`include "wcf_defs.vh"
module waveform_curve_framer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int NPTS = 256;
	logic aclk = 0;
	logic aresetn = 0;
	logic slow = 0;
	logic [7:0] s_axi_awaddr = 0;
	logic [7:0] s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0;
	logic [3:0] s_axi_wstrb = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [7:0] tx_data;
	logic tx_valid, tx_ready, tx_end;
	logic [8:0] exp_q[$];
	int error_cnt = 0;
	int checks_done = 0;
	logic [1:0] bresp_seen;
	always #10 aclk = !aclk;
	wcf_framer u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_ready(tx_ready), .tx_end(tx_end));
	wcf_link_sink u_sink (.aclk(aclk), .aresetn(aresetn), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_end(tx_end), .slow(slow), .tx_ready(tx_ready));
	//////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		bresp_seen = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	//////////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] smp(int i);
		return 8'(i * 7);
	endfunction
	function automatic logic [7:0] hexc(logic [3:0] v);
		return v < 10 ? 8'h30 + v : 8'h37 + v;
	endfunction
	task automatic push(input logic [7:0] b, input logic e = 1'b0);
		exp_q.push_back({e, b});
	endtask
	task automatic build(input logic [1:0] q, enc, input logic w, t);
		logic [7:0] sum, v, c;
		logic [15:0] cnt;
		string hd;
		hd = "CURVE ";
		exp_q.delete();
		if (q != `WCF_Q_CURVE) begin
			push(8'h41);
			push(8'h62);
			if (q == `WCF_Q_PRE) begin
				push(`WCF_CH_CR);
				push(`WCF_CH_LF, 1'b1);
				return;
			end
			push(`WCF_CH_SEMI);
		end
		foreach (hd[i])
			push(hd[i]);
		cnt = 16'((w ? 2 : 1) * NPTS + 1);
		sum = cnt[15:8] + cnt[7:0];
		if (enc == `WCF_ENC_RAW) begin
			push(`WCF_CH_PCT);
			push(cnt[15:8]);
			push(cnt[7:0]);
		end
		if (enc == `WCF_ENC_HEX) begin
			push(`WCF_CH_HASH);
			push(`WCF_CH_H);
			for (int k = 3; k >= 0; k--)
				push(hexc(cnt[k*4 +: 4]));
		end
		for (int i = 0; i < cnt - 1; i++) begin
			v = smp(i);
			sum += v;
			if (enc == `WCF_ENC_RAW)
				push(v);
			else if (enc == `WCF_ENC_HEX) begin
				push(hexc(v[7:4]));
				push(hexc(v[3:0]));
			end else begin
				if (i > 0)
					push(`WCF_CH_COMMA);
				if (v > 99)
					push(8'h30 + v / 100);
				if (v > 9)
					push(8'h30 + v / 10 % 10);
				push(8'h30 + v % 10);
			end
		end
		c = -sum;
		if (enc == `WCF_ENC_RAW)
			push(c, !t);
		if (enc == `WCF_ENC_HEX) begin
			push(hexc(c[7:4]));
			push(hexc(c[3:0]), !t);
		end
		if (t || enc == `WCF_ENC_DEC) begin
			push(`WCF_CH_CR);
			push(`WCF_CH_LF, 1'b1);
		end
	endtask
	task automatic run(input logic [1:0] q, enc, input logic w, t, x);
		logic [31:0] rd;
		logic [1:0] rr;
		build(q, enc, w, t);
		u_sink.got_q.delete();
		axi_wr(`WCF_CFG_OFS, {3'h0, 13'(NPTS), 11'h0, x, t, w, enc}, 4'hf);
		axi_wr(`WCF_CTRL_OFS, {29'h0, q, 1'b1}, 4'hf);
		while (!(u_sink.got_q.size() > 0 && u_sink.got_q[$][8]))
			@(posedge aclk);
		chk(u_sink.got_q.size(), exp_q.size(), "stream length");
		foreach (exp_q[i])
			chk(u_sink.got_q[i], exp_q[i], "stream byte");
		axi_rd(`WCF_STAT_OFS, rd, rr);
		chk(rd[2:0], 3'h4, "status after transfer");
		axi_rd(`WCF_CTRL_OFS, rd, rr);
		chk(rd[2:1], q, "last query kind");
	endtask
	//////////////////////////////////////////////////////////////////////////////
	task automatic t_raw();
		logic [7:0] s;
		slow <= 1'b1;
		run(`WCF_Q_CURVE, `WCF_ENC_RAW, 1'b0, 1'b0, 1'b0);
		s = 8'h0;
		for (int i = 7; i < u_sink.got_q.size(); i++)
			s += u_sink.got_q[i][7:0];
		chk(s, 8'h0, "checksum over count and data");
		slow <= 1'b0;
		run(`WCF_Q_CURVE, `WCF_ENC_RAW, 1'b1, 1'b1, 1'b0);
		$display("raw test done");
	endtask
	task automatic t_text();
		slow <= 1'b1;
		for (int w = 0; w < 2; w++)
			run(`WCF_Q_CURVE, `WCF_ENC_HEX, w[0], w[0], 1'b0);
		run(`WCF_Q_CURVE, `WCF_ENC_DEC, 1'b0, 1'b0, 1'b0);
		$display("text test done");
	endtask
	task automatic t_pre();
		slow <= 1'b0;
		run(`WCF_Q_PRE, `WCF_ENC_RAW, 1'b0, 1'b1, 1'b0);
		run(`WCF_Q_FULL, `WCF_ENC_RAW, 1'b0, 1'b1, 1'b0);
		$display("preamble test done");
	endtask
	task automatic t_refuse();
		logic [31:0] rd;
		logic [1:0] rr;
		u_sink.got_q.delete();
		axi_wr(`WCF_CFG_OFS, 32'h0100_0010, 4'hf);
		axi_wr(`WCF_CTRL_OFS, 32'h1, 4'hf);
		repeat (40) @(posedge aclk);
		chk(u_sink.got_q.size(), 0, "raw sent under flow control");
		axi_rd(`WCF_STAT_OFS, rd, rr);
		chk(rd[1], 1'b1, "refused flag");
		axi_rd(`WCF_CFG_OFS, rd, rr);
		chk(rd, 32'h0100_0010, "config readback");
		axi_rd(8'h40, rd, rr);
		chk(rr, 2'h2, "unmapped read response");
		chk(rd, 32'h0, "unmapped read data");
		axi_wr(8'h40, 32'h0, 4'hf);
		chk(bresp_seen, 2'h2, "unmapped write response");
		axi_wr(`WCF_STAT_OFS, 32'h6, 4'hf);
		chk(bresp_seen, 2'h0, "status clear write response");
		axi_rd(`WCF_STAT_OFS, rd, rr);
		chk(rd[2:0], 3'h0, "status cleared");
		run(`WCF_Q_CURVE, `WCF_ENC_HEX, 1'b0, 1'b1, 1'b1);
		$display("refusal test done");
	endtask
	//////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		axi_wr(`WCF_SMPW_OFS, 32'h0, 4'h0);
		for (int i = 0; i < 2 * NPTS; i++)
			axi_wr(`WCF_SMPW_OFS, {24'h0, smp(i)}, 4'h1);
		axi_wr(`WCF_PREW_OFS, 32'h0, 4'h0);
		axi_wr(`WCF_PREW_OFS, 32'h0002_0041, 4'h1);
		axi_wr(`WCF_PREW_OFS, 32'h0002_0062, 4'h1);
		t_raw();
		t_text();
		t_pre();
		t_refuse();
		stop_test();
	end
	// Whole run needs well under this span; a hang lands here
	initial begin
		#1000000;
		error_cnt++;
		stop_test();
	end
endmodule
`default_nettype wire

// *** testbench/wcf_framer_sva.sv ***
`default_nettype none
module wcf_framer_sva (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, active low
	input wire logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [1:0] s_axi_bresp, // Write response
	input wire logic s_axi_arvalid, // Read address valid
	input wire logic s_axi_arready, // Read address ready
	input wire logic s_axi_rvalid, // Read response valid
	input wire logic s_axi_rready, // Read response ready
	input wire logic [1:0] s_axi_rresp, // Read response
	input wire logic [31:0] s_axi_rdata, // Read data
	input wire logic [7:0] tx_data, // Outgoing byte
	input wire logic tx_valid, // Byte valid
	input wire logic tx_ready, // Link takes byte
	input wire logic tx_end // End marker
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	property p_tx_hold;
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_end);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx byte dropped early");
	property p_end_valid;
		tx_end |-> tx_valid;
	endproperty
	a_end_valid: assert property (p_end_valid) else $error("end marker alone");
	property p_end_gap;
		tx_valid && tx_ready && tx_end |=> !tx_valid;
	endproperty
	a_end_gap: assert property (p_end_gap) else $error("byte after end marker");
	property p_b_once;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_once: assert property (p_b_once) else $error("write response repeated");
	property p_r_once;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_r_once: assert property (p_r_once) else $error("read response repeated");
	property p_r_lat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_lat: assert property (p_r_lat) else $error("read answer late");
	property p_resp_code;
		(s_axi_bvalid |-> !s_axi_bresp[0]) and (s_axi_rvalid |-> !s_axi_rresp[0]);
	endproperty
	a_resp_code: assert property (p_resp_code) else $error("bad response code");
	property p_err_zero;
		s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0;
	endproperty
	a_err_zero: assert property (p_err_zero) else $error("error read not zero");
endmodule
bind wcf_framer wcf_framer_sva u_sva (
	.aclk(aclk), .aresetn(aresetn), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.s_axi_rresp(s_axi_rresp), .s_axi_rdata(s_axi_rdata), .tx_data(tx_data),
	.tx_valid(tx_valid), .tx_ready(tx_ready), .tx_end(tx_end)
);
`default_nettype wire

// *** testbench/wcf_link_sink.sv ***
`default_nettype none
// Remote controller end: takes bytes, slow mode stalls three cycles in four
module wcf_link_sink (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, active low
	input wire logic [7:0] tx_data, // Byte from framer
	input wire logic tx_valid, // Byte valid
	input wire logic tx_end, // End marker
	input wire logic slow, // Stall often
	output logic tx_ready // Byte taken
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] got_q[$];
	logic [1:0] ph_reg;
	always @(posedge aclk) begin
		if (!aresetn) begin
			ph_reg <= 2'h0;
			tx_ready <= 1'b0;
		end else begin
			ph_reg <= ph_reg + 2'h1;
			// Ready does not wait for valid, so stalls land mid-byte too
			tx_ready <= !slow || ph_reg == 2'h3;
			if (tx_valid && tx_ready)
				got_q.push_back({tx_end, tx_data});
		end
	end
endmodule
`default_nettype wire
